// ### spr_pkg.sv
package spr_pkg;

    // ------------------------------------------------------------
    // Sizes of the crossbar
    // ------------------------------------------------------------
    localparam int NUM_PADS = 32;
    localparam int OUT_SIGS = 83;
    localparam int IN_SIGS = 61;
    localparam int PAD_W = 5;
    localparam int OUT_W = 7;
    localparam int IN_W = 6;
    localparam int ADDR_W = 12;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_CONTROL = 10'h040;
    localparam logic [9:0] IDX_OUT_PAD = 10'h041;
    localparam logic [9:0] IDX_OUT_SIG = 10'h042;
    localparam logic [9:0] IDX_IN_SIG = 10'h043;
    localparam logic [9:0] IDX_IN_PAD = 10'h044;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_SOFT_RESET_BIT = 0;
    localparam int CTRL_ENABLE_BIT = 1;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------
    // Code ranges and fixed drive codes
    // ------------------------------------------------------------
    localparam logic [7:0] PAD_CODE_LIMIT = 8'h20;
    localparam logic [4:0] DIGITAL_PAD_ZERO = 5'h10;
    localparam logic [7:0] OUT_CODE_MAX = 8'h52;
    localparam logic [7:0] IN_CODE_MAX = 8'h3c;
    localparam logic [6:0] CODE_DRIVE_LOW = 7'h3d;
    localparam logic [6:0] CODE_DRIVE_HIGH = 7'h3e;
    localparam logic [6:0] CODE_TRISTATE = 7'h3f;

    // Control register as seen by the router logic
    typedef struct packed {
        logic enable;
        logic soft_reset;
    } spr_ctrl_s;

endpackage

// ### spr_map_table.sv
// One stored mapping per entry, cleared together on a soft reset
module spr_map_table #(
    parameter int ENTRIES = 32,
    parameter int CODE_W = 7,
    parameter int IDX_W = $clog2(ENTRIES)
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Update side
    input wire logic clear,
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [CODE_W-1:0] wr_code,
    // Stored mappings
    output logic [ENTRIES-1:0] valid,
    output logic [ENTRIES*CODE_W-1:0] codes
);

    // ------------------------------------------------------------
    // Per-entry storage
    // ------------------------------------------------------------
    for (genvar e = 0; e < ENTRIES; e++)
    begin : g_entry
        logic valid_q;
        logic [CODE_W-1:0] code_q;
        wire logic hit = wr_en & (wr_idx == IDX_W'(e));

        // Clear outranks a write landing in the same cycle
        always_ff @(posedge clock or negedge reset_n)
        begin
            if (!reset_n)
            begin
                valid_q <= 1'b0;
                code_q <= '0;
            end
            else if (clear)
            begin
                valid_q <= 1'b0;
                code_q <= '0;
            end
            else if (hit)
            begin
                valid_q <= 1'b1;
                code_q <= wr_code;
            end
        end

        assign valid[e] = valid_q;
        assign codes[e*CODE_W +: CODE_W] = code_q;
    end

endmodule

// ### spr_router.sv
// Notes on behaviour
// [RULE_01] Any peripheral signal can reach any pad through two register writes. periph_out 61-63 reach no pad: codes 61-63 are the fixed drive codes.
// [RULE_02] Software keeps converter signals on analogue-capable pads only.
// [RULE_03] Control bit 1 enables the router; while clear nothing is routed.
// [RULE_04] Writing 1 to control bit 0 resets the router and the bit reads 0.
// [RULE_05] The output pad choice only holds a value until the signal write.
// [RULE_06] Writing the output signal choice maps that code to the held pad.
// [RULE_07] Software writes the output pad choice before the signal choice.
// [RULE_08] The input signal choice only holds a value until the pad write.
// [RULE_09] Writing the input pad choice maps that pad to the held signal.
// [RULE_10] Software writes the input signal choice before the pad choice.
// [RULE_11] Pad codes 0-15 are analogue-capable pads, 16-31 digital pads.
// [RULE_12] Output codes reach 82; 61 drives low, 62 high, 63 tristates.
// [RULE_13] Input codes run 0 to 60, each naming one peripheral input.
// [RULE_14] Software changes no mapping while its signals are active.
// [RULE_15] Any reset clears all mappings and choices, leaving nothing routed.
//
// Our own choice: register access over APB.
module spr_router (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [spr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral side
    input wire logic [spr_pkg::OUT_SIGS-1:0] periph_out,
    output logic [spr_pkg::IN_SIGS-1:0] periph_in,
    // Pad side
    input wire logic [spr_pkg::NUM_PADS-1:0] pad_in,
    output logic [spr_pkg::NUM_PADS-1:0] pad_out,
    output logic [spr_pkg::NUM_PADS-1:0] pad_oe
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    spr_pkg::spr_ctrl_s ctrl_q;
    logic [7:0] opad_q;
    logic [7:0] osig_q;
    logic [7:0] isig_q;
    logic [7:0] ipad_q;

    // Setup phase seen, then one access cycle with pready high
    wire logic setup = psel & ~penable;
    wire logic access = psel & penable & pready_q;
    wire logic aligned = (paddr[1:0] == 2'b00);
    wire logic [9:0] idx = paddr[spr_pkg::ADDR_W-1:2];
    wire logic hit_ctrl = aligned & (idx == spr_pkg::IDX_CONTROL);
    wire logic hit_opad = aligned & (idx == spr_pkg::IDX_OUT_PAD);
    wire logic hit_osig = aligned & (idx == spr_pkg::IDX_OUT_SIG);
    wire logic hit_isig = aligned & (idx == spr_pkg::IDX_IN_SIG);
    wire logic hit_ipad = aligned & (idx == spr_pkg::IDX_IN_PAD);
    wire logic hit_any = hit_ctrl | hit_opad | hit_osig | hit_isig | hit_ipad;

    // Registers are one byte wide, so only lane 0 carries a write
    wire logic wr = access & pwrite & pstrb[0];
    wire logic wr_ctrl = wr & hit_ctrl;
    wire logic wr_opad = wr & hit_opad;
    wire logic wr_osig = wr & hit_osig;
    wire logic wr_isig = wr & hit_isig;
    wire logic wr_ipad = wr & hit_ipad;
    wire logic [7:0] wbyte = pwdata[7:0];

    // Read mux; the soft reset bit always reads back as zero
    wire logic [7:0] ctrl_rd = {6'h00, ctrl_q.enable, 1'b0}; // RULE_04
    wire logic [7:0] rd_byte = ({8{hit_ctrl}} & ctrl_rd)
        | ({8{hit_opad}} & opad_q)
        | ({8{hit_osig}} & osig_q)
        | ({8{hit_isig}} & isig_q)
        | ({8{hit_ipad}} & ipad_q);

    // Answer registered during setup, so every transfer takes two cycles
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= setup & ~hit_any;
            prdata_q <= (setup & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Control and choice registers
    // ------------------------------------------------------------
    // A soft reset request lasts one cycle and then clears itself.
    // Enable and reset written together: the reset wins next cycle.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q <= '0;
        end
        else
        begin
            ctrl_q.soft_reset <= wr_ctrl
                & wbyte[spr_pkg::CTRL_SOFT_RESET_BIT]; // RULE_04
            if (ctrl_q.soft_reset)
                ctrl_q.enable <= 1'b0; // RULE_15
            else if (wr_ctrl)
                ctrl_q.enable <= wbyte[spr_pkg::CTRL_ENABLE_BIT]; // RULE_03
        end
    end

    // Choice registers hold plain values; writing the output pad or input signal choice routes nothing
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            opad_q <= spr_pkg::REG_RESET;
            osig_q <= spr_pkg::REG_RESET;
            isig_q <= spr_pkg::REG_RESET;
            ipad_q <= spr_pkg::REG_RESET;
        end
        else if (ctrl_q.soft_reset)
        begin
            opad_q <= spr_pkg::REG_RESET; // RULE_15
            osig_q <= spr_pkg::REG_RESET;
            isig_q <= spr_pkg::REG_RESET;
            ipad_q <= spr_pkg::REG_RESET;
        end
        else
        begin
            if (wr_opad)
                opad_q <= wbyte; // RULE_05
            if (wr_osig)
                osig_q <= wbyte;
            if (wr_isig)
                isig_q <= wbyte; // RULE_08
            if (wr_ipad)
                ipad_q <= wbyte;
        end
    end

    // ------------------------------------------------------------
    // Mapping tables
    // ------------------------------------------------------------
    // Codes beyond the tables are ignored rather than aliased
    wire logic opad_ok = opad_q < spr_pkg::PAD_CODE_LIMIT; // RULE_11
    wire logic ocode_ok = wbyte <= spr_pkg::OUT_CODE_MAX; // RULE_12
    wire logic isig_ok = isig_q <= spr_pkg::IN_CODE_MAX; // RULE_13
    wire logic ipad_ok = wbyte < spr_pkg::PAD_CODE_LIMIT;
    wire logic out_map_wr = wr_osig & opad_ok & ocode_ok; // RULE_06
    wire logic in_map_wr = wr_ipad & isig_ok & ipad_ok; // RULE_09

    logic [spr_pkg::NUM_PADS-1:0] out_valid;
    logic [spr_pkg::NUM_PADS*spr_pkg::OUT_W-1:0] out_code;
    logic [spr_pkg::IN_SIGS-1:0] in_valid;
    logic [spr_pkg::IN_SIGS*spr_pkg::PAD_W-1:0] in_pad;

    // Output table: one signal code per pad
    spr_map_table #(
        .ENTRIES(spr_pkg::NUM_PADS),
        .CODE_W(spr_pkg::OUT_W)
    ) u_out_table (
        .clock(clock),
        .reset_n(reset_n),
        .clear(ctrl_q.soft_reset),
        .wr_en(out_map_wr),
        .wr_idx(opad_q[spr_pkg::PAD_W-1:0]),
        .wr_code(wbyte[spr_pkg::OUT_W-1:0]),
        .valid(out_valid),
        .codes(out_code)
    );

    // Input table: one pad code per peripheral input
    spr_map_table #(
        .ENTRIES(spr_pkg::IN_SIGS),
        .CODE_W(spr_pkg::PAD_W)
    ) u_in_table (
        .clock(clock),
        .reset_n(reset_n),
        .clear(ctrl_q.soft_reset),
        .wr_en(in_map_wr),
        .wr_idx(isig_q[spr_pkg::IN_W-1:0]),
        .wr_code(wbyte[spr_pkg::PAD_W-1:0]),
        .valid(in_valid),
        .codes(in_pad)
    );

    // ------------------------------------------------------------
    // Pad input synchronisers
    // ------------------------------------------------------------
    logic [spr_pkg::NUM_PADS-1:0] pad_meta_q;
    logic [spr_pkg::NUM_PADS-1:0] pad_sync_q;

    // Pads are asynchronous to the clock; two stages before any use
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pad_meta_q <= '0;
            pad_sync_q <= '0;
        end
        else
        begin
            pad_meta_q <= pad_in;
            pad_sync_q <= pad_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Crossbar
    // ------------------------------------------------------------
    logic [spr_pkg::NUM_PADS-1:0] pad_out_d;
    logic [spr_pkg::NUM_PADS-1:0] pad_oe_d;
    logic [spr_pkg::IN_SIGS-1:0] periph_in_d;

    // Output side: each pad looks up its own code
    for (genvar p = 0; p < spr_pkg::NUM_PADS; p++)
    begin : g_pad
        wire logic [6:0] oc = out_code[p*spr_pkg::OUT_W +: spr_pkg::OUT_W];
        wire logic used = ctrl_q.enable & out_valid[p]; // RULE_03
        wire logic is_low = (oc == spr_pkg::CODE_DRIVE_LOW);
        wire logic is_high = (oc == spr_pkg::CODE_DRIVE_HIGH);
        wire logic is_tri = (oc == spr_pkg::CODE_TRISTATE);
        wire logic fixed = is_low | is_high | is_tri;
        // Unmapped and tristated pads are released, not driven low
        assign pad_oe_d[p] = used & ~is_tri; // RULE_12
        assign pad_out_d[p] = used & (is_high | (~fixed & periph_out[oc]));
    end

    // Input side: disabled or unmapped inputs read as zero
    for (genvar s = 0; s < spr_pkg::IN_SIGS; s++)
    begin : g_input
        wire logic [4:0] ip = in_pad[s*spr_pkg::PAD_W +: spr_pkg::PAD_W];
        assign periph_in_d[s] = ctrl_q.enable & in_valid[s]
            & pad_sync_q[ip]; // RULE_01
    end

    // All crossbar outputs are registered to keep pad timing clean
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pad_out <= '0;
            pad_oe <= '0;
            periph_in <= '0;
        end
        else
        begin
            pad_out <= pad_out_d;
            pad_oe <= pad_oe_d;
            periph_in <= periph_in_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    wire logic [6:0] held_out_code =
        out_code[opad_q[4:0]*spr_pkg::OUT_W +: spr_pkg::OUT_W];
    wire logic [4:0] held_in_pad =
        in_pad[isig_q[5:0]*spr_pkg::PAD_W +: spr_pkg::PAD_W];
    wire logic [4:0] pad16 = spr_pkg::DIGITAL_PAD_ZERO;
    wire logic [6:0] code16 = out_code[pad16*spr_pkg::OUT_W +: 7];
    wire logic [4:0] uart_rx_pad = in_pad[17*spr_pkg::PAD_W +: 5];

    a_out_map_capture: assert property ( // RULE_06
        out_map_wr |=> out_valid[opad_q[4:0]]
            && held_out_code == $past(wbyte[6:0]))
        else $error("output mapping not captured on signal write");

    a_pad_choice_only: assert property ( // RULE_05
        wr_opad |=> $stable(out_valid) && $stable(out_code))
        else $error("pad choice write changed the output table");

    a_in_map_capture: assert property ( // RULE_09
        in_map_wr |=> in_valid[isig_q[5:0]]
            && held_in_pad == $past(wbyte[4:0]))
        else $error("input mapping not captured on pad write");

    a_sig_choice_only: assert property ( // RULE_08
        wr_isig |=> $stable(in_valid) && $stable(in_pad))
        else $error("signal choice write changed the input table");

    a_soft_reset_clear: assert property ( // RULE_04
        wr_ctrl && wbyte[0] |-> ##2 (out_valid == '0 && in_valid == '0
            && !ctrl_q.enable && opad_q == 8'h00 && isig_q == 8'h00))
        else $error("soft reset left state behind");

    a_ctrl_reads_zero: assert property ( // RULE_04
        setup && !pwrite && hit_ctrl |=> pready && prdata[0] == 1'b0)
        else $error("soft reset bit read back as one");

    a_disabled_quiet: assert property ( // RULE_03
        !ctrl_q.enable |=> pad_oe == '0 && periph_in == '0)
        else $error("router drives while disabled");

    a_fixed_drive: assert property ( // RULE_12
        ctrl_q.enable && out_valid[pad16] && code16 == 7'h3e
            |=> pad_oe[16] && pad_out[16])
        else $error("drive high code did not drive the pad high");

    a_tristate_code: assert property ( // RULE_12
        out_map_wr && wbyte[6:0] == spr_pkg::CODE_TRISTATE
            |=> ##1 !pad_oe[opad_q[4:0]])
        else $error("tristate code still drives the pad");

    a_bad_code_ignored: assert property ( // RULE_12
        wr_osig && wbyte > spr_pkg::OUT_CODE_MAX
            |=> $stable(out_valid) && $stable(out_code))
        else $error("out of range output code was stored");

    a_input_route: assert property ( // RULE_13
        ctrl_q.enable && in_valid[17]
            |=> periph_in[17] == $past(pad_sync_q[uart_rx_pad]))
        else $error("input mapping does not follow its pad");

    a_bus_answer: assert property (
        setup |=> pready ##1 !pready)
        else $error("access phase not answered in one cycle");

    c_out_mapping: cover property (wr_opad ##[2:20] out_map_wr);
    c_in_mapping: cover property (wr_isig ##[2:20] in_map_wr);
    c_soft_reset: cover property (out_valid != '0 ##1 ctrl_q.soft_reset);
    c_pad_driven: cover property (ctrl_q.enable && pad_oe != '0);

endmodule

// ### spr_far_side.sv
module spr_far_side (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Bench control
    input wire logic run,
    input wire logic [spr_pkg::OUT_SIGS-1:0] pattern,
    input wire logic [spr_pkg::NUM_PADS-1:0] ext_level,
    // Router side
    input wire logic [spr_pkg::NUM_PADS-1:0] pad_out,
    input wire logic [spr_pkg::NUM_PADS-1:0] pad_oe,
    output logic [spr_pkg::OUT_SIGS-1:0] periph_out,
    output logic [spr_pkg::NUM_PADS-1:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // -------------------------------------------------------------
    // Peripherals and board
    // -------------------------------------------------------------
    // Peripherals stay quiet while the router is being reconfigured
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            periph_out <= '0;
        else if (run)
            periph_out <= pattern;
    end

    // A driven pad reads back its drive, a free pad shows the board
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

// ### test_signal_pad_router.sv
module test_signal_pad_router;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(nm, ex, ac) begin checks++; if ((ac) !== (ex)) begin \
    err_total++; $display("CHECK FAILED %s exp %h got %h", nm, ex, ac); \
    end end

    // -------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [spr_pkg::OUT_SIGS-1:0] periph_out;
    logic [spr_pkg::IN_SIGS-1:0] periph_in;
    logic [spr_pkg::NUM_PADS-1:0] pad_in;
    logic [spr_pkg::NUM_PADS-1:0] pad_out;
    logic [spr_pkg::NUM_PADS-1:0] pad_oe;
    logic run = 1'b0;
    logic [spr_pkg::OUT_SIGS-1:0] pat = '0;
    logic [spr_pkg::NUM_PADS-1:0] ext = '0;
    logic [32:0] exp_q[$];
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    int unsigned rnd;

    always #2 clock = ~clock;

    spr_router DUT (.clock(clock), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_out(periph_out),
        .periph_in(periph_in), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe));

    spr_far_side far (.clock(clock), .reset_n(reset_n), .run(run),
        .pattern(pat), .ext_level(ext), .pad_out(pad_out),
        .pad_oe(pad_oe), .periph_out(periph_out), .pad_in(pad_in));

    // -------------------------------------------------------------
    // Stimulus helpers
    // -------------------------------------------------------------
    // Fresh random levels only while the far side is allowed to move
    always @(posedge clock)
    begin
        if (run)
        begin
            pat <= spr_pkg::OUT_SIGS'({$urandom, $urandom, $urandom});
            ext <= $urandom;
        end
    end

    function automatic logic [11:0] ra(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction

    task automatic complete_run();
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One APB transfer; the answer is noted for the watcher first
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [7:0] d, input logic [3:0] s, input logic [7:0] rv,
        input logic er);
        exp_q.push_back({er, 24'h0, rv});
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        // Only the bench timeout ends a wait that never sees pready
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, ra(idx), d, 4'h1, 8'h00, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] v,
        input logic er);
        apb(1'b0, a, 8'h00, 4'h0, v, er);
    endtask

    // Pad choice alone must not drive; the signal write maps it
    task automatic out_map(input logic [7:0] pad, input logic [7:0] code);
        logic [1:0] ex;
        wr(spr_pkg::IDX_OUT_PAD, pad);
        repeat (2) @(posedge clock);
        `CHK("pad_oe held", 1'b0, pad_oe[pad[4:0]])
        wr(spr_pkg::IDX_OUT_SIG, code);
        repeat (2) @(posedge clock);
        ex = {1'b1, periph_out[code]};
        if (code == 8'd61)
            ex = 2'b10;
        if (code == 8'd62)
            ex = 2'b11;
        `CHK("pad_oe map", ex[1] & (code != 8'd63), pad_oe[pad[4:0]])
        if (code != 8'd63)
            `CHK("pad_out map", ex[0], pad_out[pad[4:0]])
    endtask

    // Signal choice alone must not route; the pad write maps it
    task automatic in_map(input logic [7:0] sig, input logic [7:0] pad);
        wr(spr_pkg::IDX_IN_SIG, sig);
        repeat (5) @(posedge clock);
        `CHK("periph_in held", 1'b0, periph_in[sig[5:0]])
        wr(spr_pkg::IDX_IN_PAD, pad);
        repeat (5) @(posedge clock);
        `CHK("periph_in map", pad_in[pad[4:0]], periph_in[sig[5:0]])
    endtask

    // -------------------------------------------------------------
    // Watcher and timeout
    // -------------------------------------------------------------
    always @(posedge clock)
    begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
        begin
            `CHK("prdata", exp_q[0][31:0], prdata)
            `CHK("pslverr", exp_q[0][32], pslverr)
            void'(exp_q.pop_front());
        end
    end

    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            complete_run();
        end
    end

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial
    begin
        logic [7:0] pads[5];
        logic [7:0] codes[5];
        rnd = $urandom(57755);
        pads = '{8'd24, 8'd0, 8'd31, 8'd5, 8'd16};
        codes = '{8'd18, 8'd61, 8'd62, 8'd63, 8'($urandom_range(60))};
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        // Reset values, then refused and ignored accesses
        for (int i = 0; i < 5; i++)
            rd(ra(spr_pkg::IDX_CONTROL + 10'(i)), 8'h00, 1'b0);
        rd(ra(10'h045), 8'h00, 1'b1);
        rd(12'h101, 8'h00, 1'b1);
        apb(1'b1, ra(10'h045), 8'h02, 4'h1, 8'h00, 1'b1);
        apb(1'b1, ra(spr_pkg::IDX_OUT_PAD), 8'h1f, 4'h0, 8'h00, 1'b0);
        rd(ra(spr_pkg::IDX_OUT_PAD), 8'h00, 1'b0);
        wr(spr_pkg::IDX_CONTROL, 8'h02);
        rd(ra(spr_pkg::IDX_CONTROL), 8'h02, 1'b0);
        run <= 1'b1;
        repeat (4) @(posedge clock);
        run <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 5; i++)
            out_map(pads[i], codes[i]);
        // Signal write alone re-uses the pad still held
        wr(spr_pkg::IDX_OUT_SIG, 8'd62);
        repeat (2) @(posedge clock);
        `CHK("pad_out reuse", 2'b11, {pad_oe[16], pad_out[16]})
        rd(ra(spr_pkg::IDX_OUT_PAD), 8'd16, 1'b0);
        // Out of range code is stored but leaves the mapping alone
        wr(spr_pkg::IDX_OUT_SIG, 8'h53);
        repeat (2) @(posedge clock);
        `CHK("pad_out bad code", 2'b11, {pad_oe[16], pad_out[16]})
        rd(ra(spr_pkg::IDX_OUT_SIG), 8'h53, 1'b0);
        in_map(8'd17, 8'd22);
        in_map(8'd60, 8'd0);
        in_map(8'd0, 8'd31);
        in_map(8'(18 + $urandom_range(38)), 8'(1 + $urandom_range(29)));
        // Disable, then soft reset together with enable
        wr(spr_pkg::IDX_CONTROL, 8'h00);
        repeat (3) @(posedge clock);
        `CHK("pad_oe off", 32'h0, pad_oe)
        `CHK("periph_in off", 61'h0, periph_in)
        wr(spr_pkg::IDX_CONTROL, 8'h03);
        rd(ra(spr_pkg::IDX_CONTROL), 8'h00, 1'b0);
        wr(spr_pkg::IDX_CONTROL, 8'h02);
        repeat (3) @(posedge clock);
        `CHK("pad_oe clear", 32'h0, pad_oe)
        `CHK("periph_in clear", 61'h0, periph_in)
        rd(ra(spr_pkg::IDX_OUT_PAD), 8'h00, 1'b0);
        rd(ra(spr_pkg::IDX_IN_SIG), 8'h00, 1'b0);
        // Hardware reset in mid-run drops a live mapping
        wr(spr_pkg::IDX_OUT_SIG, 8'd62);
        repeat (2) @(posedge clock);
        `CHK("pad_oe live", 1'b1, pad_oe[0])
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        `CHK("pad_oe reset", 32'h0, pad_oe)
        rd(ra(spr_pkg::IDX_CONTROL), 8'h00, 1'b0);
        rd(ra(spr_pkg::IDX_OUT_SIG), 8'h00, 1'b0);
        repeat (2) @(posedge clock);
        complete_run();
    end
endmodule
